//--- prc_map.vh
`ifndef PRC_MAP_VH
`define PRC_MAP_VH
// ----------------------------------------
// register indices (printed values are word indices, not byte addresses: byte address is index * 4)
// ----------------------------------------
`define PRC_IDX_PORT_ZERO_LATCH   8'h80
`define PRC_IDX_STACK_POINTER     8'h81
`define PRC_IDX_DATA_PTR_LOW      8'h82
`define PRC_IDX_DATA_PTR_HIGH     8'h83
`define PRC_IDX_CS0_ADDR_LOW      8'h84
`define PRC_IDX_CS0_ADDR_HIGH     8'h85
`define PRC_IDX_PORT_OPTION       8'h86
`define PRC_IDX_POWER_CONTROL     8'h87
`define PRC_IDX_STATUS            8'h88
`define PRC_IDX_BIT_ACCESS        8'h89
// ----------------------------------------
// reset values
// ----------------------------------------
`define PRC_RST_PORT              8'hff
`define PRC_RST_STACK             8'h07
`define PRC_RST_ZERO              8'h00
`define PRC_RST_POWER_CONTROL     8'h30
// ----------------------------------------
// power control fields
// ----------------------------------------
`define PRC_PC_IDLE               0
`define PRC_PC_PDOWN              1
`define PRC_PC_GF0                2
`define PRC_PC_GF1                3
`define PRC_PC_POF                4
`define PRC_PC_FES                6
`define PRC_PC_BAUD               7
`define PRC_PC_RW_MASK            8'hcc
`define PRC_PORT_OPTION_PULLUP           0
// ----------------------------------------
// timing: a machine cycle is 12 clocks; state5 phase2 is clock 9 of 12
// ----------------------------------------
`define PRC_MC_CLKS               4'd12
`define PRC_STATE5_PHASE2_PHASE            4'd9
`define PRC_RST_MIN_SAMPLES       2'd2
`define PRC_OSC_SETTLE_US         100
`define PRC_CLK_MHZ               20
`define PRC_OSC_SETTLE_CLKS       (`PRC_OSC_SETTLE_US * `PRC_CLK_MHZ)
`endif

//--- prc_power_reset_control.v
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`include "prc_map.vh"

// Overview of operation
// - idle request stops processor clock; peripheral and interrupt clocks keep running
// - any interrupt or reset ends idle and restarts processor clock
// - power-down request stops every clock including the oscillator
// - power-down ends only on hardware reset or enabled external irq zero/one
// - reset sampled at state5 phase2, needs two consecutive machine-cycle samples
// - reset loads ports ff, stack pointer 07, power control 20h plus power-on flag, other registers 00
// - reset does not clear the power-on flag
// - power-on reset sets power-on flag; software clears it by writing zero
// - baud doubler bit doubles serial baud in modes 1, 2, 3
// - frame-error select makes serial control bit7 the framing error flag
// - power control bits 3 and 2 are plain software flags
// - port zero pullup bit zero gives open-drain, one gives pull-ups
// - port zero resets open-drain and carries muxed address/data externally
// - stack pointer addresses scratchpad ram only, top of stack
// - data pointer low at 82h, high at 83h form 16-bit pointer
// - of the registers with low three bits zero, only the port zero latch at 80h is bit-addressable
module prc_power_reset_control (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    input  wire        i_por,
    input  wire        i_reset_pin,
    input  wire        i_irq_any,
    input  wire        i_external_irq_zero,
    input  wire        i_external_irq_one,
    input  wire        i_ext_irq_zero_en,
    input  wire        i_ext_irq_one_en,
    input  wire [1:0]  i_serial_mode,
    input  wire        i_framing_error_flag,
    input  wire        i_serial_std_bit7,
    input  wire        i_ext_mem_access,
    input  wire [7:0]  i_ext_addr_low,
    input  wire [7:0]  i_ext_data_out,
    input  wire [7:0]  i_port_zero_pin,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    output reg         o_cpu_clk_en,
    output reg         o_periph_clk_en,
    output reg         o_osc_en,
    output reg         o_sys_reset,
    output reg         o_baud_double,
    output reg         o_serial_control_bit7,
    output reg  [7:0]  o_port_zero_out,
    output reg  [7:0]  o_port_zero_oe_n,
    output reg  [7:0]  o_port_zero_pullup,
    output reg  [15:0] o_data_pointer,
    output reg  [7:0]  o_stack_pointer,
    output reg  [15:0] o_cs0_addr
);

    localparam ST_RUN    = 2'd0;
    localparam ST_IDLE   = 2'd1;
    localparam ST_PDOWN  = 2'd2;
    localparam ST_SETTLE = 2'd3;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    reg  [6:0]  sync1_r;
    reg  [6:0]  sync2_r;
    wire [6:0]  raw_in = {i_por, i_reset_pin, i_irq_any, i_external_irq_zero,
                          i_external_irq_one, i_ext_irq_zero_en, i_ext_irq_one_en};

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    wire por_s   = sync2_r[6];
    wire rst_s   = sync2_r[5];
    wire irq_s   = sync2_r[4];
    // external irq pins are active low
    wire wake_pd = (!sync2_r[3] && sync2_r[1]) || (!sync2_r[2] && sync2_r[0]);

    // ----------------------------------------
    // reset filter
    // ----------------------------------------
    reg [3:0] phase_r;
    reg [1:0] hits_r;
    reg       reset_r;
    reg       por_seen_r;
    wire      sample = (phase_r == `PRC_STATE5_PHASE2_PHASE);
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_r    <= 4'h0;
            hits_r     <= 2'h0;
            reset_r    <= 1'b1;
            por_seen_r <= 1'b0;
        end else begin
            phase_r <= (phase_r == `PRC_MC_CLKS - 4'd1) ? 4'h0 : phase_r + 4'd1;
            por_seen_r <= por_s;

            // a lone high sample is treated as a glitch
            if (sample) begin
                if (!rst_s) begin
                    hits_r  <= 2'h0;
                    reset_r <= 1'b0;
                end else if (hits_r == `PRC_RST_MIN_SAMPLES - 2'd1) begin
                    hits_r  <= `PRC_RST_MIN_SAMPLES;
                    reset_r <= 1'b1;
                end else if (hits_r != `PRC_RST_MIN_SAMPLES) begin
                    hits_r <= hits_r + 2'd1;
                end
            end
        end
    end

    wire sw_reset = reset_r || por_s;

    // ----------------------------------------
    // apb register file
    // ----------------------------------------
    reg [7:0] port_zero_latch_r;
    reg [7:0] stack_pointer_r;

    reg [7:0] data_pointer_low_r;
    reg [7:0] data_pointer_high_r;

    reg [7:0] cs0_addr_low_r;
    reg [7:0] cs0_addr_high_r;

    reg [7:0] port_option_r;
    reg [7:0] power_control_r;
    reg [1:0] state_r;

    // request bits drop only on the event that really ends the mode
    wire wake_now = ((state_r == ST_IDLE) && irq_s) || ((state_r == ST_PDOWN) && wake_pd);

    wire       acc     = i_psel && i_penable;
    wire [9:0] idx     = i_paddr[11:2];

    wire       aligned = (i_paddr[1:0] == 2'b00);
    wire       mapped  = aligned && (idx[9:8] == 2'b00) &&
                         (idx[7:0] >= `PRC_IDX_PORT_ZERO_LATCH) &&
                         (idx[7:0] <= `PRC_IDX_BIT_ACCESS);

    wire       wr      = acc && i_pwrite && mapped;

    function [7:0] reg_read;
        input [7:0] a;
        begin
            case (a)
                `PRC_IDX_PORT_ZERO_LATCH: reg_read = port_zero_latch_r;
                `PRC_IDX_STACK_POINTER:   reg_read = stack_pointer_r;
                `PRC_IDX_DATA_PTR_LOW:    reg_read = data_pointer_low_r;
                `PRC_IDX_DATA_PTR_HIGH:   reg_read = data_pointer_high_r;
                `PRC_IDX_CS0_ADDR_LOW:    reg_read = cs0_addr_low_r;
                `PRC_IDX_CS0_ADDR_HIGH:   reg_read = cs0_addr_high_r;
                `PRC_IDX_PORT_OPTION:     reg_read = port_option_r;
                `PRC_IDX_POWER_CONTROL:   reg_read = power_control_r;
                `PRC_IDX_STATUS:          reg_read = {5'h00, reset_r, state_r};
                default:                  reg_read = 8'h00;
            endcase
        end
    endfunction

    // bit access: wdata[7:0] target, [10:8] bit, [11] value; only 80h (port zero latch) is bit-addressable
    wire [7:0] bit_tgt  = i_pwdata[7:0];
    wire       bit_ok   = (bit_tgt[2:0] == 3'b000) &&
                          (bit_tgt == `PRC_IDX_PORT_ZERO_LATCH);

    wire       bit_wr   = wr && (idx[7:0] == `PRC_IDX_BIT_ACCESS) && bit_ok;
    wire [7:0] bit_mask = 8'h01 << i_pwdata[10:8];
    wire [7:0] bit_val  = i_pwdata[11] ? (port_zero_latch_r | bit_mask)
                                       : (port_zero_latch_r & ~bit_mask);

    function wr_hit;
        input [7:0] a;
        begin
            wr_hit = wr && (idx[7:0] == a);
        end
    endfunction

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_zero_latch_r   <= `PRC_RST_PORT;
            stack_pointer_r     <= `PRC_RST_STACK;
            data_pointer_low_r  <= `PRC_RST_ZERO;
            data_pointer_high_r <= `PRC_RST_ZERO;

            cs0_addr_low_r      <= `PRC_RST_ZERO;
            cs0_addr_high_r     <= `PRC_RST_ZERO;

            port_option_r       <= `PRC_RST_ZERO;

            power_control_r     <= `PRC_RST_POWER_CONTROL;
        end else if (sw_reset) begin
            port_zero_latch_r   <= `PRC_RST_PORT;
            stack_pointer_r     <= `PRC_RST_STACK;
            data_pointer_low_r  <= `PRC_RST_ZERO;
            data_pointer_high_r <= `PRC_RST_ZERO;
            cs0_addr_low_r      <= `PRC_RST_ZERO;
            cs0_addr_high_r     <= `PRC_RST_ZERO;
            port_option_r       <= `PRC_RST_ZERO;

            // power-on flag kept through a pin reset, set by power-on
            power_control_r     <= {3'b001, power_control_r[`PRC_PC_POF] | por_s,
                                    4'h0};
        end else begin
            if (wr_hit(`PRC_IDX_PORT_ZERO_LATCH)) begin
                port_zero_latch_r <= i_pwdata[7:0];
            end else if (bit_wr) begin
                port_zero_latch_r <= bit_val;
            end

            // scratchpad address only: full 8-bit internal ram range
            if (wr_hit(`PRC_IDX_STACK_POINTER)) begin
                stack_pointer_r <= i_pwdata[7:0];
            end

            if (wr_hit(`PRC_IDX_DATA_PTR_LOW)) begin
                data_pointer_low_r <= i_pwdata[7:0];
            end

            if (wr_hit(`PRC_IDX_DATA_PTR_HIGH)) begin
                data_pointer_high_r <= i_pwdata[7:0];
            end

            if (wr_hit(`PRC_IDX_CS0_ADDR_LOW)) begin
                cs0_addr_low_r <= i_pwdata[7:0];
            end

            if (wr_hit(`PRC_IDX_CS0_ADDR_HIGH)) begin
                cs0_addr_high_r <= i_pwdata[7:0];
            end

            if (wr_hit(`PRC_IDX_PORT_OPTION)) begin
                port_option_r <= {7'h00, i_pwdata[`PRC_PORT_OPTION_PULLUP]};
            end

            if (wr_hit(`PRC_IDX_POWER_CONTROL)) begin
                // request bits self-clear on wake; flags and pof store plainly
                power_control_r <= (i_pwdata[7:0] & `PRC_PC_RW_MASK) | 8'h20 |
                                   {3'b000, i_pwdata[`PRC_PC_POF], 2'b00,
                                    i_pwdata[`PRC_PC_PDOWN],
                                    i_pwdata[`PRC_PC_IDLE]};
            end else if (wake_now) begin
                power_control_r[`PRC_PC_IDLE]  <= 1'b0;
                power_control_r[`PRC_PC_PDOWN] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // power mode sequencer
    // ----------------------------------------
    reg [11:0] settle_r;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r  <= ST_RUN;
            settle_r <= 12'h000;
        end else if (sw_reset) begin
            state_r  <= ST_RUN;
            settle_r <= 12'h000;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (power_control_r[`PRC_PC_PDOWN]) begin
                        state_r <= ST_PDOWN;
                    end else if (power_control_r[`PRC_PC_IDLE]) begin
                        state_r <= ST_IDLE;
                    end
                end

                ST_IDLE: begin
                    if (irq_s) begin
                        state_r <= ST_RUN;
                    end
                end

                ST_PDOWN: begin
                    if (wake_pd) begin
                        state_r  <= ST_SETTLE;
                        settle_r <= 12'h000;
                    end
                end

                ST_SETTLE: begin
                    // clocks stay gated for the whole oscillator restart
                    if (settle_r == `PRC_OSC_SETTLE_CLKS - 1) begin
                        state_r <= ST_RUN;
                    end else begin
                        settle_r <= settle_r + 12'd1;
                    end
                end

                default: state_r <= ST_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // outputs and apb answer
    // ----------------------------------------
    wire [7:0] p0_drive = i_ext_mem_access ? i_ext_addr_low : port_zero_latch_r;

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !mapped;

            o_prdata  <= (i_psel && !i_penable && mapped)
                         ? {24'h000000, reg_read(idx[7:0])} : 32'h0000_0000;
        end
    end

    // every clock runs while reset is applied, so the core can load its defaults
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cpu_clk_en          <= 1'b1;
            o_periph_clk_en       <= 1'b1;
            o_osc_en              <= 1'b1;
            o_sys_reset           <= 1'b1;
            o_baud_double         <= 1'b0;
            o_serial_control_bit7 <= 1'b0;

            o_port_zero_out       <= 8'hff;
            o_port_zero_oe_n      <= 8'hff;
            o_port_zero_pullup    <= 8'h00;

            o_data_pointer        <= 16'h0000;
            o_stack_pointer       <= `PRC_RST_STACK;
            o_cs0_addr            <= 16'h0000;
        end else begin
            o_cpu_clk_en    <= (state_r == ST_RUN) || sw_reset;
            o_periph_clk_en <= (state_r == ST_RUN) || (state_r == ST_IDLE) ||
                               sw_reset;
            o_osc_en        <= (state_r != ST_PDOWN) || sw_reset;

            o_sys_reset     <= sw_reset;

            o_baud_double   <= power_control_r[`PRC_PC_BAUD] &&
                               (i_serial_mode != 2'd0);
            o_serial_control_bit7 <= power_control_r[`PRC_PC_FES] ?
                                     i_framing_error_flag : i_serial_std_bit7;

            o_port_zero_out <= i_ext_mem_access && !i_pwrite ? i_ext_data_out : p0_drive;

            // open-drain: only drive zeros; pull-up mode drives ones too
            o_port_zero_oe_n <= i_ext_mem_access ? 8'h00 :
                                (port_option_r[`PRC_PORT_OPTION_PULLUP] ? 8'h00
                                                                 : port_zero_latch_r);
            o_port_zero_pullup <= {8{port_option_r[`PRC_PORT_OPTION_PULLUP]}};

            o_data_pointer  <= {data_pointer_high_r, data_pointer_low_r};
            o_stack_pointer <= stack_pointer_r;
            o_cs0_addr      <= {cs0_addr_high_r, cs0_addr_low_r};
        end
    end

endmodule

//--- prc_power_reset_control_chk.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checks for the power and reset controller
// ----------------------------------------
module prc_power_reset_control_chk (
    input wire        i_core_clk,
    input wire        i_rst_n,
    input wire        i_psel,
    input wire        i_penable,
    input wire [1:0]  i_serial_mode,
    input wire        i_framing_error_flag,
    input wire        i_serial_std_bit7,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire        o_cpu_clk_en,
    input wire        o_periph_clk_en,
    input wire        o_osc_en,
    input wire        o_sys_reset,
    input wire        o_baud_double,
    input wire        o_serial_control_bit7,
    input wire [15:0] o_data_pointer,
    input wire [7:0]  o_stack_pointer
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    pready_cause_a: assert property (o_pready |-> i_psel && i_penable
        && $past(i_psel && !i_penable)) else $error("pready without setup");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    err_data_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("refused access with data");
    upper_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    pdown_clocks_a: assert property (!o_osc_en |-> !o_periph_clk_en && !o_cpu_clk_en)
        else $error("clock running with oscillator off");
    reset_load_a: assert property (o_sys_reset && $past(o_sys_reset) |->
        o_stack_pointer == 8'h07 && o_data_pointer == 16'h0000) else $error("reset values");
    reset_run_a: assert property (o_sys_reset [*3] |-> o_cpu_clk_en && o_osc_en)
        else $error("clocks stopped in reset");
    baud_mode_a: assert property (i_serial_mode == 2'd0 && $past(i_serial_mode) == 2'd0
        |-> !o_baud_double) else $error("baud doubled in mode zero");
    fe_pass_a: assert property ($past(i_framing_error_flag) == $past(i_serial_std_bit7)
        |-> o_serial_control_bit7 == $past(i_serial_std_bit7)) else $error("bit7 source");
endmodule

bind prc_power_reset_control prc_power_reset_control_chk u_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_serial_mode(i_serial_mode), .i_framing_error_flag(i_framing_error_flag),
    .i_serial_std_bit7(i_serial_std_bit7), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en),
    .o_osc_en(o_osc_en), .o_sys_reset(o_sys_reset), .o_baud_double(o_baud_double),
    .o_serial_control_bit7(o_serial_control_bit7), .o_data_pointer(o_data_pointer),
    .o_stack_pointer(o_stack_pointer));

//--- prc_pin_source.sv
`timescale 1ns/100ps
// ----------------------------------------
// reset pin and external irq pins
// ----------------------------------------
module prc_pin_source (
    input  wire  i_clk,
    output logic o_reset_pin,
    output logic o_irq_zero_n,
    output logic o_irq_one_n
);
    initial begin
        o_reset_pin  = 1'b0;
        o_irq_zero_n = 1'b1;
        o_irq_one_n  = 1'b1;
    end
    // option bit 7 stays low: the 20 MHz bench clock is below 25 MHz
    // callers below 13 clocks make a glitch on purpose
    task automatic drive_reset(input int n);
        o_reset_pin <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_reset_pin <= 1'b0;
    endtask
    // pins are pulled up, so release returns them high
    task automatic drive_irq(input int which, input int n);
        if (which == 1)
            o_irq_one_n <= 1'b0;
        else
            o_irq_zero_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_irq_zero_n <= 1'b1;
        o_irq_one_n  <= 1'b1;
    endtask
endmodule

//--- test_power_reset_control.sv
`timescale 1ns/100ps
`include "prc_map.vh"
// ----------------------------------------
// bench for the power and reset controller
// ----------------------------------------
module test_power_reset_control;
    localparam logic [7:0] pc = `PRC_IDX_POWER_CONTROL;
    logic        clk, rst_n, por, irq_any, en0, en1, fe_flag, std7, psel, penable, pwrite;
    logic        ext_acc;
    logic [1:0]  smode;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, cpu_en, per_en, osc_en, sys_rst, baud, sc7;
    wire         reset_pin, irq0_n, irq1_n;
    wire  [7:0]  p0_out, p0_oe_n, p0_pu, sp;
    wire  [15:0] dp, cs0;
    int          mismatches, check_count, cycles;

    prc_pin_source src (.i_clk(clk), .o_reset_pin(reset_pin), .o_irq_zero_n(irq0_n),
                        .o_irq_one_n(irq1_n));
    prc_power_reset_control DUT (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_por(por), .i_reset_pin(reset_pin),
        .i_irq_any(irq_any), .i_external_irq_zero(irq0_n), .i_external_irq_one(irq1_n),
        .i_ext_irq_zero_en(en0), .i_ext_irq_one_en(en1), .i_serial_mode(smode),
        .i_framing_error_flag(fe_flag), .i_serial_std_bit7(std7), .i_ext_mem_access(ext_acc),
        .i_ext_addr_low(8'h00), .i_ext_data_out(8'h00), .i_port_zero_pin(8'hff),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en), .o_osc_en(osc_en),
        .o_sys_reset(sys_rst), .o_baud_double(baud), .o_serial_control_bit7(sc7),
        .o_port_zero_out(p0_out), .o_port_zero_oe_n(p0_oe_n), .o_port_zero_pullup(p0_pu),
        .o_data_pointer(dp), .o_stack_pointer(sp), .o_cs0_addr(cs0));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    // opens on a fresh edge so back-to-back calls never drive psel twice at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ba(idx), d, r, e);
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(what, r, exp);
    endtask
    task automatic wait_sig(input int sel, input logic v, input int lim);
        int n;
        logic s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            s = (sel == 0) ? cpu_en : (sel == 1) ? osc_en : sys_rst;
        end while (s !== v && n < lim);
        check("wait level", 32'(s), 32'(v));
    endtask

    task automatic test_regs;
        logic [31:0] r;
        logic e;
        rdc("latch", ba(`PRC_IDX_PORT_ZERO_LATCH), 32'hff);
        rdc("stack", ba(`PRC_IDX_STACK_POINTER), 32'h07);
        for (int i = 2; i < 7; i++)
            rdc("zero reg", ba(8'(128 + i)), 32'h0);
        rdc("power ctl", ba(pc), 32'h30);
        for (int i = 1; i < 6; i++) begin
            wr(8'(128 + i), 32'(165 + i));
            rdc("rw reg", ba(8'(128 + i)), 32'(165 + i));
        end
        check("dptr", 32'(dp), 32'ha8a7);
        check("sp out", 32'(sp), 32'ha6);
        wr(`PRC_IDX_PORT_OPTION, 32'hff);
        rdc("option", ba(`PRC_IDX_PORT_OPTION), 32'h01);
        check("pullup on", 32'(p0_pu), 32'hff);
        wr(`PRC_IDX_PORT_OPTION, 32'h00);
        repeat (3) @(posedge clk);
        check("pullup off", 32'(p0_pu), 32'h00);
        wr(pc, 32'h0c);
        rdc("flags", ba(pc), 32'h2c);
        wr(`PRC_IDX_BIT_ACCESS, 32'h380);
        rdc("bit clear", ba(`PRC_IDX_PORT_ZERO_LATCH), 32'hf7);
        apb(1'b0, 12'h228, 32'h0, r, e);
        check("unmapped", 32'(e), 32'h1);
        $display("register test done");
    endtask
    task automatic test_resets;
        wr(pc, 32'h1c);
        wr(`PRC_IDX_STACK_POINTER, 32'h55);
        src.drive_reset(3);
        repeat (30) @(posedge clk);
        rdc("glitch", ba(`PRC_IDX_STACK_POINTER), 32'h55);
        src.drive_reset(30);
        check("sys reset", 32'(sys_rst), 32'h1);
        wait_sig(2, 1'b0, 60);
        rdc("sp reset", ba(`PRC_IDX_STACK_POINTER), 32'h07);
        rdc("latch reset", ba(`PRC_IDX_PORT_ZERO_LATCH), 32'hff);
        rdc("pof kept", ba(pc), 32'h30);
        check("open drain", 32'(p0_pu), 32'h00);
        wr(pc, 32'h00);
        por <= 1'b1;
        repeat (6) @(posedge clk);
        por <= 1'b0;
        wait_sig(2, 1'b0, 60);
        rdc("pof set", ba(pc), 32'h30);
        $display("reset test done");
    endtask
    task automatic test_idle;
        wr(pc, 32'h11);
        wait_sig(0, 1'b0, 10);
        repeat (20) @(posedge clk);
        check("idle cpu", 32'({cpu_en, per_en, osc_en}), 32'h3);
        irq_any <= 1'b1;
        wait_sig(0, 1'b1, 10);
        irq_any <= 1'b0;
        rdc("idle clear", ba(pc), 32'h30);
        $display("idle test done");
    endtask
    task automatic test_pdown;
        for (int k = 0; k < 2; k++) begin
            wr(pc, 32'h12);
            wait_sig(1, 1'b0, 10);
            check("pd clocks", 32'({cpu_en, per_en}), 32'h0);
            irq_any <= 1'b1;
            src.drive_irq(k, 20);
            irq_any <= 1'b0;
            check("no wake", 32'(osc_en), 32'h0);
            if (k == 1)
                en1 <= 1'b1;
            else
                en0 <= 1'b1;
            src.drive_irq(k, 10);
            wait_sig(1, 1'b1, 20);
            repeat (1000) @(posedge clk);
            check("settle hold", 32'(cpu_en), 32'h0);
            wait_sig(0, 1'b1, 1200);
            en0 <= 1'b0;
            en1 <= 1'b0;
        end
        $display("power-down test done");
    endtask
    task automatic test_serial;
        wr(pc, 32'h80);
        for (int m = 0; m < 4; m++) begin
            smode <= 2'(m);
            repeat (4) @(posedge clk);
            check("baud", 32'(baud), 32'(m != 0));
        end
        wr(pc, 32'h40);
        fe_flag <= 1'b1;
        repeat (3) @(posedge clk);
        check("fe select", 32'(sc7), 32'h1);
        wr(pc, 32'h00);
        repeat (3) @(posedge clk);
        check("std bit7", 32'(sc7), 32'h0);
        ext_acc <= 1'b1;
        repeat (3) @(posedge clk);
        check("ext drive", 32'(p0_oe_n), 32'h0);
        ext_acc <= 1'b0;
        $display("serial test done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // run takes about 4400 clocks; a hang is cut at 12000, nearly three times that
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 12000) begin
                mismatches++;
                print_verdict();
            end
        end
    end
    initial begin
        {rst_n, por, irq_any, en0, en1, fe_flag, std7, psel, penable, pwrite, ext_acc} = '0;
        smode = 2'd0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wait_sig(2, 1'b0, 60);
        test_regs();
        test_resets();
        test_idle();
        test_pdown();
        test_serial();
        print_verdict();
    end
endmodule
